// File: design/stcpwm_timer.sv
// Standard timer with two comparators, compare-match, timer and PWM modes.
// Assumes an APB master on clk and a pin driver outside that honours pinOe_n.
`timescale 1ns/1ps
module stcpwm_timer
    import stcpwm_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer output pin
    output logic timerOutputPin,
    output logic timerOutputPinOe_n,
    // Match event flags
    output logic matchAFlag,
    output logic matchPFlag
);

    // =========================================================
    // State
    typedef struct packed {
        stcpwm_ctl_type ctl;
        logic pause;
        logic [1:0] prescale;
        logic counterRun;
        logic runPrev;
        logic [5:0] divCount;
        logic [COUNT_WIDTH-1:0] count;
        logic [COUNT_WIDTH-1:0] compareA;
        logic [7:0] compareP;
        logic matchA;
        logic matchP;
        logic pinLevel;
        logic pinOut;
        logic pinOe_n;
        stcpwm_apb_resp_type resp;
    } stcpwm_state_type;

    stcpwm_state_type s_q;
    stcpwm_state_type s_d;

    // =========================================================
    // Combinational helpers
    logic [COUNT_WIDTH:0] incCount;
    logic tick;
    logic runRise;
    logic hitA;
    logic hitP;
    logic pwmMode;
    logic captureMode;
    logic [COUNT_WIDTH:0] periodLen;
    logic [COUNT_WIDTH:0] dutyLen;
    logic [COUNT_WIDTH:0] pLen;
    logic pwmActive;
    logic [7:0] rdByte;
    logic mapped;
    logic clrA;
    logic clrP;
    logic wrStatus;
    logic [1:0] setFlags;
    logic waveLevel;

    always_comb begin
        s_d = s_q;
        // Prescaler divides clk by 1, 4, 16 or 64 to form the timer tick.
        s_d.divCount = s_q.divCount + 6'h01;
        case (s_q.prescale)
            2'h0: tick = 1'b1;
            2'h1: tick = (s_q.divCount[1:0] == 2'h3);
            2'h2: tick = (s_q.divCount[3:0] == 4'hF);
            default: tick = (s_q.divCount == 6'h3F);
        endcase
        tick = tick && s_q.counterRun && !s_q.pause;
        runRise = s_q.counterRun && !s_q.runPrev;
        s_d.runPrev = s_q.counterRun;
        pwmMode = (s_q.ctl.modeSelect == MODE_PWM);
        captureMode = (s_q.ctl.modeSelect == MODE_CAPTURE);

        // Match detection on the value the counter is about to take.
        incCount = {1'b0, s_q.count} + {{COUNT_WIDTH{1'b0}}, 1'b1};
        hitA = (incCount[COUNT_WIDTH-1:0] == s_q.compareA) && (s_q.compareA != RESET_WORD);
        if (s_q.compareP == RESET_BYTE) begin
            hitP = incCount[COUNT_WIDTH];
        end else begin
            hitP = (incCount[COUNT_WIDTH-1:0] == {s_q.compareP, 8'h00});
        end

        // Period and duty lengths for PWM.
        pLen = (s_q.compareP == RESET_BYTE) ? {1'b1, {COUNT_WIDTH{1'b0}}} :
            {1'b0, s_q.compareP, 8'h00};
        if (s_q.ctl.dutyPeriodSwap) begin
            periodLen = {1'b0, s_q.compareA};
            dutyLen = pLen;
        end else begin
            periodLen = pLen;
            dutyLen = {1'b0, s_q.compareA};
        end
        pwmActive = ({1'b0, s_q.count} < dutyLen) || (dutyLen >= periodLen);

        // Counter: run rise clears, pause and stop hold.
        clrA = 1'b0;
        clrP = 1'b0;
        setFlags = 2'h0;
        if (runRise) begin
            s_d.count = RESET_WORD;
        end else if (tick) begin
            if (pwmMode) begin
                clrA = s_q.ctl.dutyPeriodSwap && hitA;
                clrP = !s_q.ctl.dutyPeriodSwap && hitP;
                setFlags = {hitP, hitA};
            end else if (captureMode) begin
                clrP = hitP;
                setFlags = {hitP, 1'b0};
            end else if (s_q.ctl.clearSourceSelect) begin
                clrA = hitA;
                setFlags = {1'b0, hitA};
            end else begin
                clrP = hitP;
                setFlags = {hitP, hitA};
            end
            if (clrA || clrP) begin
                s_d.count = RESET_WORD;
            end else begin
                s_d.count = incCount[COUNT_WIDTH-1:0];
            end
        end

        // Pin level in compare-match and PWM modes.
        if (runRise) begin
            s_d.pinLevel = s_q.ctl.initialLevel;
        end else if (tick && hitA && !pwmMode && !captureMode) begin
            case (s_q.ctl.pinAction)
                ACT_LOW: s_d.pinLevel = 1'b0;
                ACT_HIGH: s_d.pinLevel = 1'b1;
                ACT_TOGGLE: s_d.pinLevel = !s_q.pinLevel;
                default: s_d.pinLevel = s_q.pinLevel;
            endcase
        end
        case (s_q.ctl.pinAction)
            PWM_INACTIVE: waveLevel = !s_q.ctl.initialLevel;
            PWM_ACTIVE: waveLevel = s_q.ctl.initialLevel;
            PWM_WAVE: waveLevel = pwmActive ? s_q.ctl.initialLevel : !s_q.ctl.initialLevel;
            default: waveLevel = !s_q.ctl.initialLevel;
        endcase
        case (s_q.ctl.modeSelect)
            MODE_COMPARE: begin
                s_d.pinOut = s_d.pinLevel ^ s_q.ctl.outputInvert;
                s_d.pinOe_n = 1'b0;
            end
            MODE_PWM: begin
                s_d.pinOut = waveLevel ^ s_q.ctl.outputInvert;
                s_d.pinOe_n = 1'b0;
            end
            default: begin
                s_d.pinOut = 1'b0;
                s_d.pinOe_n = 1'b1;
            end
        endcase

        // APB: one wait state, answer registered, write at the ready edge.
        mapped = 1'b1;
        case (paddr)
            ADDR_CONTROL_ZERO: rdByte = {s_q.pause, 1'b0, s_q.prescale, s_q.counterRun, 3'h0};
            ADDR_CONTROL_ONE: rdByte = {s_q.ctl.modeSelect, s_q.ctl.pinAction, s_q.ctl.initialLevel,
                s_q.ctl.outputInvert, s_q.ctl.dutyPeriodSwap, s_q.ctl.clearSourceSelect};
            ADDR_COUNTER_LOW: rdByte = s_q.count[7:0];
            ADDR_COUNTER_HIGH: rdByte = s_q.count[15:8];
            ADDR_COMPARE_A_LOW: rdByte = s_q.compareA[7:0];
            ADDR_COMPARE_A_HIGH: rdByte = s_q.compareA[15:8];
            ADDR_COMPARE_P: rdByte = s_q.compareP;
            ADDR_STATUS: rdByte = {6'h00, s_q.matchP, s_q.matchA};
            default: begin
                rdByte = RESET_BYTE;
                mapped = 1'b0;
            end
        endcase
        wrStatus = 1'b0;
        if (psel && penable && !s_q.resp.pready) begin
            s_d.resp.pready = 1'b1;
            s_d.resp.pslverr = !mapped;
            s_d.resp.prdata = pwrite ? 32'h0000_0000 : {24'h000000, rdByte};
        end else begin
            s_d.resp.pready = 1'b0;
            s_d.resp.pslverr = 1'b0;
            if (psel && penable && pwrite && mapped) begin
                case (paddr)
                    ADDR_CONTROL_ZERO: begin
                        s_d.pause = pwdata[CTL0_PAUSE_BIT];
                        s_d.prescale = pwdata[CTL0_PRESCALE_HI:CTL0_PRESCALE_LO];
                        s_d.counterRun = pwdata[CTL0_RUN_BIT];
                    end
                    ADDR_CONTROL_ONE: begin
                        s_d.ctl.modeSelect = pwdata[7:6];
                        s_d.ctl.pinAction = pwdata[5:4];
                        s_d.ctl.initialLevel = pwdata[3];
                        s_d.ctl.outputInvert = pwdata[2];
                        s_d.ctl.dutyPeriodSwap = pwdata[1];
                        s_d.ctl.clearSourceSelect = pwdata[0];
                    end
                    ADDR_COMPARE_A_LOW: s_d.compareA[7:0] = pwdata[7:0];
                    ADDR_COMPARE_A_HIGH: s_d.compareA[15:8] = pwdata[7:0];
                    ADDR_COMPARE_P: s_d.compareP = pwdata[7:0];
                    ADDR_STATUS: wrStatus = 1'b1;
                    default: wrStatus = 1'b0;
                endcase
            end
        end

        // Sticky flags: write one clears, a new match in the same cycle wins.
        s_d.matchA = (s_q.matchA && !(wrStatus && pwdata[STAT_MATCH_A_BIT])) || setFlags[0];
        s_d.matchP = (s_q.matchP && !(wrStatus && pwdata[STAT_MATCH_P_BIT])) || setFlags[1];
    end

    // =========================================================
    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.pinOe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // Outputs
    assign prdata = s_q.resp.prdata;
    assign pready = s_q.resp.pready;
    assign pslverr = s_q.resp.pslverr;
    assign timerOutputPin = s_q.pinOut;
    assign timerOutputPinOe_n = s_q.pinOe_n;
    assign matchAFlag = s_q.matchA;
    assign matchPFlag = s_q.matchP;

endmodule

// File: design/stcpwm_pkg.sv
// Package for the standard timer with compare and PWM output.
// Assumes an APB master with 32-bit data and one aligned word per register.
package stcpwm_pkg;

    // =========================================================
    // Register map
    localparam logic [7:0] ADDR_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h04;
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h08;
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_COMPARE_A_LOW = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_A_HIGH = 8'h14;
    localparam logic [7:0] ADDR_COMPARE_P = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;

    // =========================================================
    // Control zero fields
    localparam int CTL0_PAUSE_BIT = 7;
    localparam int CTL0_PRESCALE_HI = 5;
    localparam int CTL0_PRESCALE_LO = 4;
    localparam int CTL0_RUN_BIT = 3;

    // =========================================================
    // Status fields
    localparam int STAT_MATCH_A_BIT = 0;
    localparam int STAT_MATCH_P_BIT = 1;

    // =========================================================
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    // =========================================================
    // Mode and pin action encodings
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] ACT_HOLD = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] PWM_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;

    // =========================================================
    // Types
    typedef struct packed {
        logic outputInvert;
        logic dutyPeriodSwap;
        logic clearSourceSelect;
        logic initialLevel;
        logic [1:0] pinAction;
        logic [1:0] modeSelect;
    } stcpwm_ctl_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } stcpwm_apb_resp_type;

endpackage

// File: tb/stcpwm_timer_properties.sv
// Checker for the timer's APB answers and its sticky match flags.
// Assumes it is bound to stcpwm_timer and sees only that module's ports.
`timescale 1ns/1ps
module stcpwm_timer_properties
    import stcpwm_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin and flags
    input wire logic timerOutputPin,
    input wire logic timerOutputPinOe_n,
    input wire logic matchAFlag,
    input wire logic matchPFlag
);
    // =========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic statusWr;
    assign statusWr = psel && penable && pready && pwrite && paddr == ADDR_STATUS;
    a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_STATUS))
        else $error("pslverr does not match decode");
    a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
    a_byte_data: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above low byte");
    a_clear_a_flag: assert property ($fell(matchAFlag) |-> $past(statusWr && pwdata[0]))
        else $error("match A flag cleared without write");
    a_clear_p_flag: assert property ($fell(matchPFlag) |-> $past(statusWr && pwdata[1]))
        else $error("match P flag cleared without write");
    c_match_a: cover property ($rose(matchAFlag));
    c_match_p: cover property ($rose(matchPFlag));
    c_error: cover property (pslverr);
endmodule

bind stcpwm_timer stcpwm_timer_properties #(.COUNT_WIDTH(COUNT_WIDTH)) u_props (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerOutputPin(timerOutputPin),
    .timerOutputPinOe_n(timerOutputPinOe_n), .matchAFlag(matchAFlag), .matchPFlag(matchPFlag));

// File: tb/test_stcpwm_timer.sv
// Testbench for the timer: APB register tests, compare and PWM scenarios.
// Assumes the design runs on a 10 MHz clock with the prescaler at divide by one.
`timescale 1ns/1ps
module test_stcpwm_timer;
    import stcpwm_pkg::*;
    // =========================================================
    // Signals and tables
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, hi;
    logic pready, pslverr, pin, pinOe_n, flagA, flagP, err;
    int miscompares = 0;
    int cmp_count = 0;
    localparam logic [7:0] REGS [5] = '{ADDR_COUNTER_LOW, ADDR_COUNTER_HIGH, ADDR_COMPARE_A_LOW,
        ADDR_COMPARE_A_HIGH, ADDR_COMPARE_P};
    localparam logic [7:0] CCTL [6] = '{8'h09, 8'h19, 8'h21, 8'h31, 8'h25, 8'hE1};
    localparam logic PRE [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic POST [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    localparam logic [7:0] PCTL [6] = '{8'hA8, 8'hAC, 8'hAA, 8'hA9, 8'h88, 8'h98};
    localparam logic [7:0] PA [6] = '{8'h40, 8'h40, 8'h80, 8'h40, 8'h40, 8'h40};
    localparam int PEXP [6] = '{64, 192, 256, 64, 0, 256};
    always #50 clk = ~clk;
    stcpwm_timer u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerOutputPin(pin), .timerOutputPinOe_n(pinOe_n), .matchAFlag(flagA), .matchPFlag(flagP));
    // =========================================================
    // Tasks
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic guard(inout int n, input int lim);
        n++;
        if (n > lim) begin
            miscompares++;
            wrap_up();
        end else begin
            @(posedge clk);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) guard(n, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_flag(input logic useP, input int lim);
        int n;
        n = 0;
        while ((useP ? flagP : flagA) !== 1'b1) guard(n, lim);
    endtask
    task automatic start(input logic [7:0] c1, input logic [7:0] a, input logic [7:0] p);
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h00);
        xfer(1'b1, ADDR_STATUS, 8'h03);
        xfer(1'b1, ADDR_COMPARE_A_LOW, a);
        xfer(1'b1, ADDR_COMPARE_P, p);
        xfer(1'b1, ADDR_CONTROL_ONE, c1);
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h08);
    endtask
    // =========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, REGS[i], 8'h00);
            check("reset value", 32'h0, rd);
            xfer(1'b1, REGS[i], 8'(8'hA5 + i));
            xfer(1'b0, REGS[i], 8'h00);
            check("written value", (i < 2) ? 32'h0 : 32'hA5 + i, rd);
        end
        xfer(1'b0, 8'h20, 8'h00);
        check("unmapped error", 32'h1, err);
        xfer(1'b1, ADDR_COMPARE_A_HIGH, 8'h00);
        $display("Register test done");
        for (int i = 0; i < 6; i++) begin
            start(CCTL[i], 8'h08, 8'h00);
            repeat (2) @(posedge clk);
            if (i < 5) check("pin at start", PRE[i], pin);
            check("pin enable", i == 5, pinOe_n);
            wait_flag(1'b0, 40);
            repeat (2) @(posedge clk);
            if (i < 5) check("pin after match", POST[i], pin);
            check("match p flag", 32'h0, flagP);
            $display("Compare test %0d done", i);
        end
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h00);
        xfer(1'b1, ADDR_STATUS, 8'h01);
        check("flag after clear", 32'h0, flagA);
        for (int i = 0; i < 2; i++) begin
            start(8'h00, (i == 0) ? 8'h08 : 8'h00, 8'h01);
            repeat (200) @(posedge clk);
            check("early p match", 32'h0, flagP);
            wait_flag(1'b1, 100);
            check("match a flag", i == 0, flagA);
            xfer(1'b0, ADDR_COUNTER_HIGH, 8'h00);
            check("counter after p", 32'h0, rd);
            $display("Period test %0d done", i);
        end
        xfer(1'b1, ADDR_COMPARE_A_HIGH, 8'h01);
        start(8'h01, 8'h08, 8'h01);
        wait_flag(1'b0, 400);
        repeat (2) @(posedge clk);
        check("p flag with a clear", 32'h0, flagP);
        xfer(1'b1, ADDR_COMPARE_A_HIGH, 8'h00);
        $display("Clear select test done");
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h00);
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h08);
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h00);
        xfer(1'b0, ADDR_COUNTER_LOW, 8'h00);
        check("count after stop", 32'h3, rd);
        repeat (10) @(posedge clk);
        xfer(1'b0, ADDR_COUNTER_LOW, 8'h00);
        check("count held", 32'h3, rd);
        xfer(1'b1, ADDR_CONTROL_ZERO, 8'h08);
        xfer(1'b0, ADDR_COUNTER_LOW, 8'h00);
        check("count after restart", 32'h1, rd);
        $display("Run test done");
        for (int i = 0; i < 6; i++) begin
            start(PCTL[i], PA[i], 8'h01);
            repeat (20) @(posedge clk);
            hi = 32'h0;
            repeat (256) begin
                @(posedge clk);
                hi = hi + (pin === 1'b1);
            end
            check("pwm high cycles", PEXP[i], hi);
            check("pwm flags", (i == 2) ? 32'h1 : 32'h3, {flagP, flagA});
            $display("PWM test %0d done", i);
        end
        wrap_up();
    end
endmodule
